// file: core/prc_rail_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "prc_regs.svh"

module prc_rail_ctrl
   import prc_pkg::*;
#(
   parameter logic [7:0]  RAIL_EN_DEFAULT  = `PRC_RST_RAIL_EN,
   parameter logic [7:0]  SLEEP_DEFAULT    = `PRC_RST_SLEEP_LOCK,
   parameter logic [7:0]  SWITCH_DEFAULT   = `PRC_RST_SWITCH_DISCH,
   parameter int unsigned TIMER_1S_CYCLES  = `PRC_TIMER_1S_CYC,
   parameter int unsigned TIMER_5S_CYCLES  = `PRC_TIMER_5S_CYC
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        regWe,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  regWdata,
   output logic      [7:0]  regRdata,
   input  wire logic        buckOneEnablePin,
   input  wire logic        buckTwoEnablePin,
   input  wire logic        buckThreeEnablePin,
   input  wire logic        regulatorEnablePin,
   input  wire logic [2:0]  regulatorSequenceSelect,
   input  wire logic        undervoltageLockout,
   input  wire logic        bandgapOk,
   input  wire logic        systemRailBelow,
   input  wire logic        ldoTwoStarted,
   output prc_rails_t       railEnable,
   output prc_rails_t       railDischarge,
   output logic      [2:0]  forcedFixedFrequency,
   output logic             externalRegulatorEnable,
   output logic             powerGoodForceLow,
   output prc_lockout_t     lockoutCfg,
   output logic             timerOneExpired,
   output logic             timerFiveExpired,
   output prc_state_t       powerState,
   output logic      [2:0]  converterSequenceSelect
);

   prc_wr_t    wr;
   logic [7:0] railEn_q;
   logic [7:0] railEn_d;
   logic [7:0] sleepLock_q;
   logic [7:0] sleepLock_d;
   logic [7:0] switchDis_q;
   logic [7:0] switchDis_d;
   prc_state_t state_q;
   prc_state_t state_d;
   prc_rails_t railOn;
   logic       primarySeq;
   logic       deepSleep;

   assign wr = '{we: regWe, addr: regAddr, data: regWdata};

   // Register next values: host writes, then hardware loads take priority
   always_comb begin
      railEn_d    = railEn_q;
      sleepLock_d = sleepLock_q;
      switchDis_d = switchDis_q;
      if (wr.we) begin
         case (wr.addr)
            `PRC_ADDR_RAIL_EN:      railEn_d    = wr.data;
            `PRC_ADDR_SLEEP_LOCK:   sleepLock_d = wr.data;
            `PRC_ADDR_SWITCH_DISCH: switchDis_d = wr.data;
            default:                ;
         endcase
      end
      // Low pin forces its enable bit back to default
      if (!buckOneEnablePin) begin
         railEn_d[`PRC_BIT_EN_BUCK1] = RAIL_EN_DEFAULT[`PRC_BIT_EN_BUCK1];
      end
      if (!buckTwoEnablePin) begin
         railEn_d[`PRC_BIT_EN_BUCK2] = RAIL_EN_DEFAULT[`PRC_BIT_EN_BUCK2];
      end
      if (!buckThreeEnablePin) begin
         railEn_d[`PRC_BIT_EN_BUCK3] = RAIL_EN_DEFAULT[`PRC_BIT_EN_BUCK3];
      end
      // Bandgap loss reloads threshold and hysteresis
      if (!bandgapOk) begin
         sleepLock_d = (sleepLock_d & ~`PRC_MASK_BG_FIELDS)
                     | (SLEEP_DEFAULT & `PRC_MASK_BG_FIELDS);
      end
      // Lockout reloads everything else, clearing memory-valid
      if (undervoltageLockout) begin
         railEn_d    = RAIL_EN_DEFAULT;
         switchDis_d = SWITCH_DEFAULT;
         sleepLock_d = (sleepLock_d & ~`PRC_MASK_UNDERVOLTAGE_LOCKOUT_FIELDS)
                     | (SLEEP_DEFAULT & `PRC_MASK_UNDERVOLTAGE_LOCKOUT_FIELDS);
         sleepLock_d[`PRC_BIT_MEM_VALID] = 1'b0;
      end
   end

   // Register storage
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         railEn_q    <= `PRC_RST_RAIL_EN;
         sleepLock_q <= `PRC_RST_SLEEP_LOCK;
         switchDis_q <= `PRC_RST_SWITCH_DISCH;
      end else begin
         railEn_q    <= railEn_d;
         sleepLock_q <= sleepLock_d;
         switchDis_q <= switchDis_d;
      end
   end

   // Coarse power state: off below threshold, sleep on request
   always_comb begin
      state_d = state_q;
      case (state_q)
         PRC_OFF: begin
            if (!systemRailBelow && !undervoltageLockout) begin
               state_d = PRC_ON;
            end
         end
         PRC_ON: begin
            if (deepSleep) begin
               state_d = PRC_SLEEP;
            end
         end
         PRC_SLEEP: begin
            if (!deepSleep) begin
               state_d = PRC_ON;
            end
         end
         default: state_d = PRC_OFF;
      endcase
      if (systemRailBelow || undervoltageLockout) begin
         state_d = PRC_OFF;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= PRC_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   assign primarySeq = (railEn_q[`PRC_BIT_SEQ_HI:`PRC_BIT_SEQ_LO] == `PRC_SEQ_PRIMARY);
   assign deepSleep  = sleepLock_q[`PRC_BIT_DEEP_SLEEP] && primarySeq
                     && (regulatorSequenceSelect == `PRC_LDO_SEQ_PRIMARY);

   // Rail enables; rails dropped by sleep or the off state all drop in the same cycle, with no ordering
   always_comb begin
      railOn.buck1 = buckOneEnablePin && railEn_q[`PRC_BIT_EN_BUCK1];
      railOn.buck2 = buckTwoEnablePin && railEn_q[`PRC_BIT_EN_BUCK2];
      railOn.buck3 = buckThreeEnablePin && railEn_q[`PRC_BIT_EN_BUCK3];
      railOn.linear_regulator_one  = regulatorEnablePin && railEn_q[`PRC_BIT_EN_LINEAR_REGULATOR_ONE];
      railOn.linear_regulator_two  = regulatorEnablePin && railEn_q[`PRC_BIT_EN_LINEAR_REGULATOR_TWO];
      if (primarySeq && sleepLock_q[`PRC_BIT_R3_OVERRIDE]) begin
         railOn.buck3 = ldoTwoStarted && railEn_q[`PRC_BIT_EN_BUCK3];
      end
      if (state_q == PRC_SLEEP) begin
         railOn.buck1 = 1'b0;
         railOn.buck3 = 1'b0;
         railOn.linear_regulator_one  = 1'b0;
         railOn.linear_regulator_two  = 1'b0;
      end
      if (state_q == PRC_OFF) begin
         railOn = '0;
      end
   end

   // Output registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         railEnable              <= '0;
         railDischarge           <= '0;
         forcedFixedFrequency    <= 3'h0;
         externalRegulatorEnable <= 1'b0;
         powerGoodForceLow       <= 1'b1;
         regRdata                <= 8'h00;
      end else begin
         railEnable              <= railOn;
         railDischarge           <= prc_rails_t'(switchDis_q[`PRC_BIT_DIS_HI:0] & ~railOn);
         forcedFixedFrequency    <= switchDis_q[`PRC_BIT_FFF_BUCK3:`PRC_BIT_FFF_BUCK1];
         externalRegulatorEnable <= (state_q != PRC_OFF);
         powerGoodForceLow       <= (state_q != PRC_ON);
         case (regAddr)
            `PRC_ADDR_RAIL_EN:      regRdata <= railEn_q;
            `PRC_ADDR_SLEEP_LOCK:   regRdata <= sleepLock_q;
            `PRC_ADDR_SWITCH_DISCH: regRdata <= switchDis_q;
            default:                regRdata <= 8'h00;
         endcase
      end
   end

   // Lockout comparator settings
   assign lockoutCfg = '{hyst500:   sleepLock_q[`PRC_BIT_HYST],
                         threshold: sleepLock_q[`PRC_BIT_THR_HI:`PRC_BIT_THR_LO]};
   assign powerState              = state_q;
   assign converterSequenceSelect = railEn_q[`PRC_BIT_SEQ_HI:`PRC_BIT_SEQ_LO];

   // State-machine timers
   prc_timer #(.PERIOD(TIMER_1S_CYCLES)) timerOne (
      .clk     (clk),
      .reset_n (reset_n),
      .enable  (sleepLock_q[`PRC_BIT_TIMER_1S]),
      .expired (timerOneExpired)
   );

   prc_timer #(.PERIOD(TIMER_5S_CYCLES)) timerFive (
      .clk     (clk),
      .reset_n (reset_n),
      .enable  (sleepLock_q[`PRC_BIT_TIMER_5S]),
      .expired (timerFiveExpired)
   );

endmodule : prc_rail_ctrl
`default_nettype wire

// file: core/prc_regs.svh
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH

// Register offsets on the serial register port
`define PRC_ADDR_RAIL_EN       8'h0D
`define PRC_ADDR_SLEEP_LOCK    8'h0E
`define PRC_ADDR_SWITCH_DISCH  8'h0F

// Field positions in the rail enable register
`define PRC_BIT_SEQ_HI         7
`define PRC_BIT_SEQ_LO         5
`define PRC_BIT_EN_BUCK1       4
`define PRC_BIT_EN_BUCK2       3
`define PRC_BIT_EN_BUCK3       2
`define PRC_BIT_EN_LINEAR_REGULATOR_ONE        1
`define PRC_BIT_EN_LINEAR_REGULATOR_TWO        0

// Field positions in the sleep and lockout register
`define PRC_BIT_TIMER_1S       7
`define PRC_BIT_TIMER_5S       6
`define PRC_BIT_MEM_VALID      5
`define PRC_BIT_DEEP_SLEEP     4
`define PRC_BIT_R3_OVERRIDE    3
`define PRC_BIT_HYST           2
`define PRC_BIT_THR_HI         1
`define PRC_BIT_THR_LO         0

// Field positions in the switching and discharge register
`define PRC_BIT_FFF_BUCK3      7
`define PRC_BIT_FFF_BUCK2      6
`define PRC_BIT_FFF_BUCK1      5
`define PRC_BIT_DIS_HI         4

// Reset values
`define PRC_RST_RAIL_EN        8'h1F
`define PRC_RST_SLEEP_LOCK     8'h00
`define PRC_RST_SWITCH_DISCH   8'h00

// Masks of the fields loaded by each load event in the sleep and lockout register
`define PRC_MASK_UNDERVOLTAGE_LOCKOUT_FIELDS   8'hF8
`define PRC_MASK_BG_FIELDS     8'h07

// Sequencing codes
`define PRC_SEQ_PRIMARY        3'h4
`define PRC_LDO_SEQ_PRIMARY    3'h7

// Timer periods in milliseconds and cycle counts at 125 MHz
`define PRC_CLK_MHZ            125
`define PRC_TIMER_1S_MS        1000
`define PRC_TIMER_5S_MS        5000
`define PRC_TIMER_1S_CYC       (`PRC_TIMER_1S_MS * 1000 * `PRC_CLK_MHZ)
`define PRC_TIMER_5S_CYC       (`PRC_TIMER_5S_MS * 1000 * `PRC_CLK_MHZ)

`endif

// file: core/prc_pkg.sv
package prc_pkg;

   // Per-rail vector: buck1, buck2, buck3, linear_regulator_one, linear_regulator_two
   typedef struct packed {
      logic buck1;
      logic buck2;
      logic buck3;
      logic linear_regulator_one;
      logic linear_regulator_two;
   } prc_rails_t;

   // Register write request from the serial port
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } prc_wr_t;

   // Lockout configuration passed out to the comparator
   typedef struct packed {
      logic       hyst500;
      logic [1:0] threshold;
   } prc_lockout_t;

   // Coarse power state
   typedef enum logic [1:0] {
      PRC_OFF,
      PRC_ON,
      PRC_SLEEP
   } prc_state_t;

endpackage : prc_pkg

// file: core/prc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prc_regs.svh"

// Enable-gated period timer; emits a one-cycle pulse per period
module prc_timer
   import prc_pkg::*;
#(
   parameter int unsigned PERIOD = 1000
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic enable,
   output logic      expired
);

   logic [39:0] cnt_q;
   logic [39:0] cnt_d;
   logic        expired_d;

   // Count while enabled, clear when disabled
   always_comb begin
      cnt_d     = 40'h0;
      expired_d = 1'b0;
      if (enable) begin
         if (cnt_q >= 40'(PERIOD - 1)) begin
            expired_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 40'h1;
         end
      end
   end

   // Register the counter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q   <= 40'h0;
         expired <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         expired <= expired_d;
      end
   end

endmodule : prc_timer
`default_nettype wire

// file: verification/prc_rail_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module prc_rail_ctrl_assertions
   import prc_pkg::*;
(
   input wire logic         clk,
   input wire logic         reset_n,
   input wire logic         regWe,
   input wire logic [7:0]   regAddr,
   input wire logic [7:0]   regWdata,
   input wire logic [7:0]   regRdata,
   input wire logic         buckOneEnablePin,
   input wire logic         undervoltageLockout,
   input wire logic         bandgapOk,
   input wire logic         systemRailBelow,
   input wire prc_rails_t   railEnable,
   input wire logic [2:0]   forcedFixedFrequency,
   input wire logic         powerGoodForceLow,
   input wire prc_lockout_t lockoutCfg,
   input wire logic         timerOneExpired,
   input wire prc_state_t   powerState
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_pin_gates_buck: assert property (!buckOneEnablePin |=> !railEnable.buck1)
      else $error("buck one on with pin low");
   a_pin_low_bit: assert property ((!buckOneEnablePin && regAddr == 8'h0D) [*2] |=> regRdata[4])
      else $error("enable bit not restored");
   a_undervoltage_lockout_clears_valid: assert property ((undervoltageLockout && regAddr == 8'h0E) [*2] |=> !regRdata[5])
      else $error("valid flag kept in lockout");
   a_bg_loads_lockout: assert property ((!bandgapOk && regAddr == 8'h0E) [*2] |=> regRdata[2:0] == 3'h0)
      else $error("lockout fields not loaded");
   a_lockout_cfg_write: assert property (regWe && regAddr == 8'h0E && bandgapOk
      |=> lockoutCfg == $past(regWdata[2:0])) else $error("lockout config wrong");
   a_fff_bit_map: assert property ((regWe && regAddr == 8'h0F && !undervoltageLockout) ##1
      (!regWe && !undervoltageLockout) |=> forcedFixedFrequency == $past(regWdata[7:5], 2))
      else $error("fixed frequency bits wrong");
   a_sleep_rails_off: assert property (powerState == PRC_SLEEP [*2]
      |-> powerGoodForceLow && !railEnable.buck1 && !railEnable.linear_regulator_two) else $error("sleep rails");
   a_rail_low_off: assert property (systemRailBelow |=> powerState == PRC_OFF)
      else $error("not off on low rail");
   a_off_no_rails: assert property (powerState == PRC_OFF [*2] |-> railEnable == '0)
      else $error("rail on while off");
   a_timer_gap: assert property (timerOneExpired |=> !timerOneExpired [*8])
      else $error("timer pulses too close");

   c_sleep: cover property (powerState == PRC_SLEEP);
   c_timer: cover property (timerOneExpired);
   c_lockout: cover property (undervoltageLockout && regAddr == 8'h0E);
endmodule : prc_rail_ctrl_assertions

bind prc_rail_ctrl prc_rail_ctrl_assertions i_prc_rail_ctrl_assertions (
   .clk(clk), .reset_n(reset_n), .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .buckOneEnablePin(buckOneEnablePin), .undervoltageLockout(undervoltageLockout),
   .bandgapOk(bandgapOk), .systemRailBelow(systemRailBelow), .railEnable(railEnable),
   .forcedFixedFrequency(forcedFixedFrequency), .powerGoodForceLow(powerGoodForceLow),
   .lockoutCfg(lockoutCfg), .timerOneExpired(timerOneExpired), .powerState(powerState)
);
`default_nettype wire

// file: verification/prc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
   input  wire logic       clk,
   output logic            regWe,
   output logic      [7:0] regAddr,
   output logic      [7:0] regWdata,
   input  wire logic [7:0] regRdata
);
   // Idle bus at time zero
   initial begin
      regWe = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
   end
   // One-byte write; data scrambled once the strobe drops
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regWe <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWe <= 1'b0;
      regWdata <= ~d;
   endtask : wr
   // Address held; data taken two edges later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      repeat (2) @(posedge clk);
      d = regRdata;
   endtask : rd
   // After wake the host drops the memory-valid flag
   task automatic clear_valid;
      wr(8'h0E, 8'h00);
   endtask : clear_valid
endmodule : prc_host_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import prc_pkg::*;
();
   logic clk;
   logic reset_n;
   logic [2:0] enPins;
   logic undervoltage_lockout;
   logic bgOk;
   logic railLow;
   logic ldoTwo;
   logic [2:0] ldoSeq;
   logic extReg;
   logic [2:0] seqSel;
   logic regWe;
   logic [7:0] regAddr;
   logic [7:0] regWdata;
   logic [7:0] regRdata;
   prc_rails_t railEn;
   prc_rails_t railDis;
   logic [2:0] fff;
   logic pgLow;
   prc_lockout_t lockCfg;
   logic tOne;
   logic tFive;
   prc_state_t pState;
   int mismatches = 0;
   int compares = 0;

   prc_host_model host (.clk(clk), .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
   prc_rail_ctrl #(.TIMER_1S_CYCLES(10), .TIMER_5S_CYCLES(20)) i_prc_rail_ctrl (
      .clk(clk), .reset_n(reset_n), .regWe(regWe), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .buckOneEnablePin(enPins[2]), .buckTwoEnablePin(enPins[1]),
      .buckThreeEnablePin(enPins[0]), .regulatorEnablePin(1'b1), .regulatorSequenceSelect(ldoSeq),
      .undervoltageLockout(undervoltage_lockout), .bandgapOk(bgOk), .systemRailBelow(railLow), .ldoTwoStarted(ldoTwo),
      .railEnable(railEn), .railDischarge(railDis), .forcedFixedFrequency(fff),
      .externalRegulatorEnable(extReg), .powerGoodForceLow(pgLow), .lockoutCfg(lockCfg),
      .timerOneExpired(tOne), .timerFiveExpired(tFive), .powerState(pState), .converterSequenceSelect(seqSel)
   );

   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic conclude;
      if (mismatches == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic ck(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask : ck

   // Wait cycles, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      ck(d, exp);
   endtask : rdck

   // Register defaults and an unmapped read
   task automatic t_defaults;
      rdck(8'h0D, 8'h1F);
      rdck(8'h0E, 8'h00);
      rdck(8'h0F, 8'h00);
      rdck(8'h10, 8'h00);
   endtask : t_defaults

   // Pin and bit truth table, bit reload on low pin
   task automatic t_enable;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         enPins <= {3{k[0]}};
         host.wr(8'h0D, k[1] ? 8'hBF : 8'hA3);
         cyc(3);
         ck({5'h0, railEn.buck1, railEn.buck2, railEn.buck3}, {5'h0, {3{k[0] & k[1]}}});
         if (k == 0) rdck(8'h0D, 8'hBF);
      end
   endtask : t_enable

   // Lockout codes and the two load events
   task automatic t_regs;
      for (int v = 0; v < 8; v++) begin
         host.wr(8'h0E, 8'(v));
         cyc(2);
         ck({5'h0, lockCfg}, 8'(v));
      end
      host.wr(8'h0E, 8'hE7);
      undervoltage_lockout <= 1'b1;
      repeat (2) @(posedge clk);
      undervoltage_lockout <= 1'b0;
      rdck(8'h0E, 8'h07);
      host.wr(8'h0E, 8'hE7);
      bgOk <= 1'b0;
      repeat (2) @(posedge clk);
      bgOk <= 1'b1;
      rdck(8'h0E, 8'hE0);
      host.clear_valid();
   endtask : t_regs

   // Fixed-frequency bits and discharge of off rails
   task automatic t_fff;
      for (int b = 5; b < 8; b++) begin
         host.wr(8'h0F, 8'(1 << b));
         cyc(2);
         ck({5'h0, fff}, 8'(1 << (b - 5)));
      end
      enPins <= 3'h0;
      host.wr(8'h0F, 8'h1F);
      cyc(3);
      ck({5'h0, railDis.buck1, railDis.buck2, railDis.buck3}, 8'h07);
      @(posedge clk);
      enPins <= 3'h7;
      cyc(3);
      ck({5'h0, railDis.buck1, railDis.buck2, railDis.buck3}, 8'h00);
   endtask : t_fff

   // Timer pulses counted over forty cycles
   task automatic t_timer;
      logic [7:0] n1;
      logic [7:0] n5;
      for (int m = 0; m < 2; m++) begin
         host.wr(8'h0E, m ? 8'h40 : 8'h80);
         cyc(2);
         n1 = 8'h00;
         n5 = 8'h00;
         repeat (40) begin
            cyc(1);
            n1 += 8'(tOne);
            n5 += 8'(tFive);
         end
         ck(n1, m ? 8'h00 : 8'h04);
         ck(n5, m ? 8'h02 : 8'h00);
      end
   endtask : t_timer

   // Deep sleep, then rail-three override
   task automatic t_sleep;
      host.wr(8'h0D, 8'h9F);
      @(posedge clk);
      ldoSeq <= 3'h3;
      host.wr(8'h0E, 8'h10);
      cyc(3);
      ck({5'h0, seqSel}, 8'h04);
      ck({6'h0, pgLow, extReg}, 8'h01);
      @(posedge clk);
      ldoSeq <= 3'h7;
      cyc(3);
      ck({5'h0, pgLow, extReg, railEn.buck2}, 8'h07);
      ck({4'h0, railEn.buck1, railEn.buck3, railEn.linear_regulator_one, railEn.linear_regulator_two}, 8'h00);
      host.wr(8'h0E, 8'h08);
      enPins <= 3'h6;
      ldoTwo <= 1'b1;
      cyc(3);
      ck({7'h0, railEn.buck3}, 8'h01);
      @(posedge clk);
      ldoTwo <= 1'b0;
      cyc(3);
      ck({7'h0, railEn.buck3}, 8'h00);
   endtask : t_sleep

   // Low system rail forces the off state
   task automatic t_off;
      @(posedge clk);
      railLow <= 1'b1;
      cyc(3);
      ck({6'h0, pState}, {6'h0, PRC_OFF});
      ck({3'h0, railEn}, 8'h00);
      ck({7'h0, extReg}, 8'h00);
      @(posedge clk);
      railLow <= 1'b0;
      cyc(2);
      ck({6'h0, pState}, {6'h0, PRC_ON});
   endtask : t_off

   // Main sequence
   initial begin
      enPins = 3'h7;
      undervoltage_lockout = 1'b0;
      bgOk = 1'b1;
      railLow = 1'b0;
      ldoTwo = 1'b0;
      ldoSeq = 3'h7;
      reset_n = 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      cyc(2);
      t_defaults();
      t_enable();
      t_regs();
      t_fff();
      t_timer();
      t_sleep();
      t_off();
      conclude();
   end

   // Watchdog
   initial begin
      #50000;
      mismatches++;
      conclude();
   end
endmodule : tb
`default_nettype wire
